// *** rtl/css_chip_select.sv ***
// chip-select decode, polarity, combining and E clock stretch for four selects
// assumes the CPU presents a 16-bit address, a 19-bit expanded address and window hits,
// sets busStart at the beginning of each bus cycle, and follows eClkOut / eHigh
// Behaviour
// - stretch only inside owning select's range
// - hold external E high extra periods
// - internal clock never stretched
// - stretch field 00..11 gives 0..3 cycles
// - stretch register field layout io,g1,g2,prog
// - reset clears stretch, program low bit normal
// - io select off at reset, validity bit
// - io select polarity bit
// - io range 4K or 8K fixed
// - program size picks top-of-map range
// - priority bit orders general against program
// - general select off at zero size
// - general size 2K to 512K or window
// - general select validity bit each
// - general select polarity bit each
// - gen1 ORed onto gen2 pin
// - gen1 ORed onto program pin
// - gen2 ORed onto program pin
// - gen2 64K or 512K space
// - gen1 64K or 512K space
// - start register compares size-valid bits
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module css_chip_select
  import css_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic specialModeFlag,  // strap, level from pin
  input wire logic [15:0] cpuAddr,  // same-clock CPU address
  input wire logic [18:0] expAddr,  // expanded address
  input wire logic win1Hit,  // address in expansion window 1
  input wire logic win2Hit,  // address in expansion window 2
  input wire logic busStart,  // one-cycle pulse: a bus cycle begins
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic eClkOut,  // external E clock
  output logic eHigh,  // internal E phase, never stretched
  output logic ioRangeSelect,
  output logic generalSelectOne,
  output logic generalSelectTwo,
  output logic programMemorySelect
);
  // ----------------------------------------
  // reset release and strap capture
  // ----------------------------------------
  logic rstMeta_reg, rstSync_reg;
  logic smMeta_reg, smSync_reg;
  // reset released through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  wire rstN = rstSync_reg;
  // mode pin synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smMeta_reg <= 1'b0;
      smSync_reg <= 1'b0;
    end else begin
      smMeta_reg <= specialModeFlag;
      smSync_reg <= smMeta_reg;
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] stretchCfg_reg, ctl_reg, g1Start_reg, g1Ctl_reg, g2Start_reg, g2Ctl_reg;
  logic [7:0] winSize_reg;
  logic strapDone_reg;  // program low stretch bit taken once after release
  logic ack_reg;  // one wait cycle then answer
  logic [7:0] idx;
  logic hit;
  assign idx = avs_address[7:0];
  assign hit = (avs_read || avs_write) && !ack_reg;
  // writes take effect at the edge where waitrequest is low
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stretchCfg_reg <= CSS_RST_STRETCH;
      ctl_reg <= CSS_RST_CTL;
      g1Start_reg <= CSS_RST_ZERO;
      g1Ctl_reg <= CSS_RST_ZERO;
      g2Start_reg <= CSS_RST_ZERO;
      g2Ctl_reg <= CSS_RST_ZERO;
      winSize_reg <= CSS_RST_ZERO;
      strapDone_reg <= 1'b0;
    end else begin
      strapDone_reg <= 1'b1;
      // normal modes get a one-cycle program stretch, caught after release
      if (!strapDone_reg) begin
        stretchCfg_reg[CSS_STR_PR] <= !smSync_reg;
      end else if (avs_write && ack_reg && avs_byteenable[0] && avs_address[9:8] == 2'b00) begin
        if (idx == CSS_IDX_STRETCH) begin
          stretchCfg_reg <= avs_writedata[7:0];
        end else if (idx == CSS_IDX_CTL) begin
          ctl_reg <= avs_writedata[7:0];
        end else if (idx == CSS_IDX_G1START) begin
          g1Start_reg <= avs_writedata[7:0];
        end else if (idx == CSS_IDX_G1CTL) begin
          g1Ctl_reg <= avs_writedata[7:0];
        end else if (idx == CSS_IDX_G2START) begin
          g2Start_reg <= avs_writedata[7:0];
        end else if (idx == CSS_IDX_G2CTL) begin
          g2Ctl_reg <= {1'b0, avs_writedata[6:0]};  // top bit not implemented
        end else if (idx == CSS_IDX_WINSIZE) begin
          winSize_reg <= avs_writedata[7:0];
        end
      end
    end
  end
  // bus answer: waitrequest high for the first cycle of each request
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= hit;
      // low for exactly the cycle in which ack_reg is high
      avs_waitrequest <= !hit;
      if (hit && avs_read) begin
        // unmapped words read zero
        if (avs_address[9:8] != 2'b00) begin
          avs_readdata <= 32'h0000_0000;
        end else if (idx == CSS_IDX_STRETCH) begin
          avs_readdata <= {24'h000000, stretchCfg_reg};
        end else if (idx == CSS_IDX_CTL) begin
          avs_readdata <= {24'h000000, ctl_reg};
        end else if (idx == CSS_IDX_G1START) begin
          avs_readdata <= {24'h000000, g1Start_reg};
        end else if (idx == CSS_IDX_G1CTL) begin
          avs_readdata <= {24'h000000, g1Ctl_reg};
        end else if (idx == CSS_IDX_G2START) begin
          avs_readdata <= {24'h000000, g2Start_reg};
        end else if (idx == CSS_IDX_G2CTL) begin
          avs_readdata <= {24'h000000, g2Ctl_reg};
        end else if (idx == CSS_IDX_WINSIZE) begin
          avs_readdata <= {24'h000000, winSize_reg};
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end
  // waitrequest leaves a flop like every other output, so the master sees no glitch
  // ----------------------------------------
  // range decode
  // ----------------------------------------
  // general select range match; shift = log2(size) bits to ignore
  function automatic logic genMatch(input logic [3:0] sz, input logic [7:0] start,
                                    input logic mx, input logic [15:0] a16,
                                    input logic [18:0] a19, input logic w1,
                                    input logic w2);
    logic [18:0] a;
    logic [18:0] base;
    logic [18:0] mask;
    logic res;
    a = mx ? a19 : {3'b000, a16};
    base = {(mx ? start[7:5] : 3'b000), start[4:0], 11'h000};
    mask = 19'h7ffff;
    res = 1'b0;
    if (sz == 4'h0) begin
      res = 1'b0;
    end else if (sz == 4'ha) begin
      res = w1;
    end else if (sz == 4'hb) begin
      res = w2;
    end else if (sz >= 4'h9) begin
      res = mx ? 1'b1 : 1'b1;  // 512K covers all
    end else begin
      // five-bit sum: code 1 (2K) needs a shift of 11, code 8 (256K) a shift of 18,
      // which a four-bit sum would wrap and so wreck the expanded-map decode
      mask = 19'h7ffff << (5'd10 + {1'b0, sz});
      if (!mx && sz >= 4'h6) begin
        res = 1'b1;  // 64K or more covers the whole CPU space
      end else begin
        res = ((a ^ base) & mask) == 19'h00000;
      end
    end
    return res;
  endfunction : genMatch
  logic ioHit, prHit, g1Hit, g2Hit, g1Win, g2Win, prWin;
  always_comb begin
    // fixed io range
    ioHit = ctl_reg[CSS_CTL_IO_SEL_ENABLE] && (cpuAddr <= CSS_IO_TOP) &&
            (!ctl_reg[CSS_CTL_IO_SEL_SIZE] || cpuAddr >= CSS_IO_BASE4K);
    // program select occupies top of map
    case (ctl_reg[CSS_CTL_PSZ +: 2])
      2'b00: prHit = 1'b1;
      2'b01: prHit = cpuAddr[15];
      2'b10: prHit = &cpuAddr[15:14];
      default: prHit = &cpuAddr[15:13];
    endcase
    prHit = prHit && ctl_reg[CSS_CTL_PEN];
    g1Hit = genMatch(g1Ctl_reg[3:0], g1Start_reg, winSize_reg[CSS_WS_MX1], cpuAddr,
                     expAddr, win1Hit, win2Hit);
    g2Hit = genMatch(g2Ctl_reg[3:0], g2Start_reg, winSize_reg[CSS_WS_MX2], cpuAddr,
                     expAddr, win1Hit, win2Hit);
    // priority between general and program on overlap
    if (ctl_reg[CSS_CTL_PRIO]) begin
      prWin = prHit && !g1Hit && !g2Hit;
      g1Win = g1Hit;
      g2Win = g2Hit && !g1Hit;
    end else begin
      prWin = prHit;
      g1Win = g1Hit && !prHit;
      g2Win = g2Hit && !g1Hit && !prHit;
    end
  end
  // ----------------------------------------
  // E clock and stretch
  // ----------------------------------------
  // E toggles every clock; a stretch holds the external copy high for extra periods
  logic eHigh_next;
  logic [2:0] stretchCnt_reg;  // remaining half periods of hold
  logic [1:0] stretchSel;
  always_comb begin
    eHigh_next = !eHigh;
    // stretch taken from the select that owns the access
    if (ioHit) begin
      stretchSel = stretchCfg_reg[CSS_STR_IO +: 2];
    end else if (g1Win) begin
      stretchSel = stretchCfg_reg[CSS_STR_G1 +: 2];
    end else if (g2Win) begin
      stretchSel = stretchCfg_reg[CSS_STR_G2 +: 2];
    end else if (prWin) begin
      stretchSel = stretchCfg_reg[CSS_STR_PR +: 2];
    end else begin
      stretchSel = 2'b00;
    end
  end
  // internal phase never pauses so timers keep time
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      eHigh <= 1'b0;
    end else begin
      eHigh <= eHigh_next;
    end
  end
  // external E: after its normal high phase it stays high 2*N extra edges
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stretchCnt_reg <= 3'd0;
      eClkOut <= 1'b0;
    end else if (stretchCnt_reg != 3'd0) begin
      stretchCnt_reg <= stretchCnt_reg - 3'd1;
      eClkOut <= 1'b1;
    end else if (busStart && eHigh && stretchSel != 2'b00) begin
      stretchCnt_reg <= {stretchSel, 1'b0} - 3'd1;
      eClkOut <= 1'b1;
    end else begin
      eClkOut <= eHigh_next;
    end
  end
  // ----------------------------------------
  // outputs: validity, combining, polarity
  // ----------------------------------------
  logic extHigh;
  assign extHigh = eHigh_next || (stretchCnt_reg != 3'd0) ||
                   (busStart && eHigh && stretchSel != 2'b00);
  logic ioV, g1V, g2V, g1Pin, g2Pin, prPin;
  always_comb begin
    ioV = ioHit && (ctl_reg[CSS_CTL_IOAV] || extHigh);
    g1V = g1Win && (g1Ctl_reg[CSS_GC_AV] || extHigh);
    g2V = g2Win && (g2Ctl_reg[CSS_GC_AV] || extHigh);
    g2Pin = g2V || (g1V && g1Ctl_reg[CSS_GC_ONTO]);
    if (g2Ctl_reg[CSS_GC_ONTOP]) begin
      g2Pin = 1'b0;  // gen2 moved to program pin
    end
    g1Pin = g1V && !g1Ctl_reg[CSS_GC_ONTO] && !g1Ctl_reg[CSS_GC_ONTOP];
    prPin = prWin || (g1V && g1Ctl_reg[CSS_GC_ONTOP]) ||
            (g2V && g2Ctl_reg[CSS_GC_ONTOP]) ||
            (g1V && g1Ctl_reg[CSS_GC_ONTO] && g2Ctl_reg[CSS_GC_ONTOP]);
  end
  // registered pins with polarity
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ioRangeSelect <= 1'b1;
      generalSelectOne <= 1'b1;
      generalSelectTwo <= 1'b1;
      programMemorySelect <= 1'b1;
    end else begin
      ioRangeSelect <= ioV ~^ ctl_reg[CSS_CTL_IO_SEL_POLARITY];
      generalSelectOne <= g1Pin ~^ g1Ctl_reg[CSS_GC_POL];
      generalSelectTwo <= g2Pin ~^ g2Ctl_reg[CSS_GC_POL];
      programMemorySelect <= !prPin;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // a stretch has two steps: the owning access starts it, then E is held
  // start of a three-cycle stretch: the access owns an 11 field, no hold running
  sequence s_stretch3_start;
    busStart && eHigh && stretchSel == 2'b11 && stretchCnt_reg == 3'd0;
  endsequence
  // external E stays high for six extra edges after its own high phase
  sequence s_held_high;
    eClkOut [*6];
  endsequence
  property p_stretch_hold;
    @(posedge clk) disable iff (!rstN)
    s_stretch3_start |=> s_held_high;
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("E not held");
  property p_internal_runs;
    // rstN in the antecedent skips the release edge, where the phase has not moved yet
    @(posedge clk) disable iff (!rstN) rstN |=> eHigh != $past(eHigh);
  endproperty
  a_internal_runs: assert property (p_internal_runs) else $error("E phase stuck");
  property p_no_stretch_outside;
    @(posedge clk) disable iff (!rstN)
    (busStart && !ioHit && !g1Win && !g2Win && !prWin && stretchCnt_reg == 3'd0) |=>
      stretchCnt_reg == 3'd0;
  endproperty
  a_no_stretch_outside: assert property (p_no_stretch_outside) else $error("stray");
  property p_zero_size;
    @(posedge clk) disable iff (!rstN) (g1Ctl_reg[3:0] == 4'h0) |-> !g1Hit;
  endproperty
  a_zero_size: assert property (p_zero_size) else $error("gen1 active at zero size");
  property p_prio;
    @(posedge clk) disable iff (!rstN)
    (ctl_reg[CSS_CTL_PRIO] && g1Hit && prHit) |-> !prWin;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");
  property p_io_off;
    @(posedge clk) disable iff (!rstN)
    !ctl_reg[CSS_CTL_IO_SEL_ENABLE] |=> ioRangeSelect == !$past(ctl_reg[CSS_CTL_IO_SEL_POLARITY]);
  endproperty
  a_io_off: assert property (p_io_off) else $error("io select while off");
  property p_onto_prog;
    @(posedge clk) disable iff (!rstN)
    (g1V && g1Ctl_reg[CSS_GC_ONTOP]) |=> !programMemorySelect;
  endproperty
  a_onto_prog: assert property (p_onto_prog) else $error("gen1 not on program");
  property p_onto_two;
    @(posedge clk) disable iff (!rstN)
    (g1V && g1Ctl_reg[CSS_GC_ONTO] && !g2Ctl_reg[CSS_GC_ONTOP]) |=>
      generalSelectTwo == $past(g2Ctl_reg[CSS_GC_POL]);
  endproperty
  a_onto_two: assert property (p_onto_two) else $error("gen1 not on gen2");
  // the mode strap lands in the program low stretch bit one edge after release
  property p_strap;
    @(posedge clk) disable iff (!rstN)
    (rstN && !strapDone_reg) |=> stretchCfg_reg[CSS_STR_PR] == !$past(smSync_reg);
  endproperty
  a_strap: assert property (p_strap) else $error("program stretch strap wrong");
  // the 4K io window never reaches below its fixed base
  property p_io_window;
    @(posedge clk) disable iff (!rstN)
    (ctl_reg[CSS_CTL_IO_SEL_SIZE] && cpuAddr < CSS_IO_BASE4K) |-> !ioHit;
  endproperty
  a_io_window: assert property (p_io_window) else $error("io select below 4K window");
  // every request is answered after exactly one wait state
  property p_one_wait;
    @(posedge clk) disable iff (!rstN)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");
endmodule : css_chip_select

// *** rtl/css_pkg.sv ***
// package for the chip-select and stretch block: offsets, field positions, reset values
// assumes one 10 MHz clock and a byte-wide register file behind Avalon-MM
package css_pkg;
  // ----------------------------------------
  // register word indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] CSS_IDX_STRETCH = 8'h5a;  // select_stretch_config
  localparam logic [7:0] CSS_IDX_CTL = 8'h5b;  // select_control_reg
  localparam logic [7:0] CSS_IDX_G1START = 8'h5c;  // gen1_start_reg
  localparam logic [7:0] CSS_IDX_G1CTL = 8'h5d;  // gen1_control_reg
  localparam logic [7:0] CSS_IDX_G2START = 8'h5e;  // gen2_start_reg
  localparam logic [7:0] CSS_IDX_G2CTL = 8'h5f;  // gen2_control_reg
  localparam logic [7:0] CSS_IDX_WINSIZE = 8'h60;  // window_size_reg
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CSS_STR_IO = 6;  // io stretch pair
  localparam int CSS_STR_G1 = 4;  // gen1 stretch pair
  localparam int CSS_STR_G2 = 2;  // gen2 stretch pair
  localparam int CSS_STR_PR = 0;  // program stretch pair
  localparam int CSS_CTL_IO_SEL_ENABLE = 7;  // io_sel_enable
  localparam int CSS_CTL_IOAV = 6;  // io_sel_addr_valid
  localparam int CSS_CTL_IO_SEL_POLARITY = 5;  // io_sel_polarity
  localparam int CSS_CTL_IO_SEL_SIZE = 4;  // io_sel_size
  localparam int CSS_CTL_PEN = 2;  // prog_sel_enable
  localparam int CSS_CTL_PSZ = 0;  // prog_size_hi:lo at 1:0
  localparam int CSS_CTL_PRIO = 3;  // general_over_program_priority
  localparam int CSS_GC_ONTO = 7;  // gen1_onto_gen2 (gen1 only)
  localparam int CSS_GC_ONTOP = 6;  // onto program
  localparam int CSS_GC_POL = 5;  // polarity
  localparam int CSS_GC_AV = 4;  // address valid
  localparam int CSS_WS_MX1 = 6;  // gen1_expanded_map
  localparam int CSS_WS_MX2 = 7;  // gen2_expanded_map
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CSS_RST_STRETCH = 8'h00;  // low bit added in normal modes
  localparam logic [7:0] CSS_RST_CTL = 8'h04;  // program select on, io off
  localparam logic [7:0] CSS_RST_ZERO = 8'h00;
  // fixed ranges
  localparam logic [15:0] CSS_IO_BASE4K = 16'h1000;
  localparam logic [15:0] CSS_IO_TOP = 16'h1fff;
endpackage : css_pkg

// *** sim/css_ext_model.sv ***
// far-side model: an external device that watches the E clock it is given
// assumes one clock; the E clock and the internal phase are sampled on its rising edge
`timescale 1ns/1ps
module css_ext_model (
  input wire logic clk,
  input wire logic eClkOut,
  input wire logic eHigh,
  input wire logic clrStats,
  output logic [7:0] maxHigh,
  output logic [7:0] eStalls
);
  logic [7:0] runLen;  // length of the current E high run
  logic eHighLast;  // internal phase one cycle back
  // ----------------------------------------
  // width of E high as a slow peripheral sees it
  // ----------------------------------------
  always_ff @(posedge clk) begin
    eHighLast <= eHigh;
    if (clrStats) begin
      runLen <= 8'h00;
      maxHigh <= 8'h00;
      eStalls <= 8'h00;
    end else begin
      runLen <= eClkOut ? runLen + 8'h01 : 8'h00;
      if (eClkOut && runLen + 8'h01 > maxHigh) begin
        maxHigh <= runLen + 8'h01;
      end
      // a frozen internal phase would upset timers, so count every stall
      if (eHigh === eHighLast) begin
        eStalls <= eStalls + 8'h01;
      end
    end
  end
endmodule : css_ext_model

// *** sim/testbench.sv ***
// self-checking bench for the chip-select block, driven over Avalon-MM
// assumes the design answers each request with one wait state
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  import css_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic specialModeFlag = 1'b0;
  logic [15:0] cpuAddr = 16'h0000;
  logic [18:0] expAddr = 19'h00000;
  logic win1Hit = 1'b0;
  logic win2Hit = 1'b0;
  logic busStart = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic eClkOut, eHigh, ioRangeSelect, generalSelectOne, generalSelectTwo;
  logic programMemorySelect;
  logic clrStats = 1'b1;  // model statistics held clear until a stretch test
  logic [7:0] maxHigh, eStalls;
  int n_fail = 0;
  int checks = 0;
  css_chip_select u_css_chip_select (.clk(clk), .arst_n(arst_n),
    .specialModeFlag(specialModeFlag), .cpuAddr(cpuAddr), .expAddr(expAddr),
    .win1Hit(win1Hit), .win2Hit(win2Hit), .busStart(busStart), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .eClkOut(eClkOut), .eHigh(eHigh),
    .ioRangeSelect(ioRangeSelect), .generalSelectOne(generalSelectOne),
    .generalSelectTwo(generalSelectTwo), .programMemorySelect(programMemorySelect));
  css_ext_model u_css_ext_model (.clk(clk), .eClkOut(eClkOut), .eHigh(eHigh),
    .clrStats(clrStats), .maxHigh(maxHigh), .eStalls(eStalls));
  // ----------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    // the whole run needs a few hundred cycles; this is ample margin
    #3000000;
    n_fail++;
    stop_test();
  end
  // ----------------------------------------
  // shared bus and probe tasks
  // ----------------------------------------
  task automatic do_reset(input logic sm);
    arst_n <= 1'b0;
    specialModeFlag <= sm;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  // request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    avs_address <= {2'b00, idx};
    avs_writedata <= {24'h000000, wd};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, d, rd);
  endtask : wr8
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, idx, 8'h00, rd);
    `CHK(rd, e)
  endtask : rdchk
  // outputs are registered one cycle after decode, so let them settle
  task automatic psel(input logic [15:0] a, input logic [18:0] x, input logic [3:0] e);
    cpuAddr <= a;
    expAddr <= x;
    repeat (3) @(posedge clk);
    `CHK({ioRangeSelect, generalSelectOne, generalSelectTwo, programMemorySelect}, e)
  endtask : psel
  task automatic stretch(input logic [15:0] a, input logic [7:0] expLen);
    cpuAddr <= a;
    expAddr <= {3'b000, a};
    clrStats <= 1'b1;
    repeat (3) @(posedge clk);
    clrStats <= 1'b0;
    do @(posedge clk); while (eHigh !== 1'b0);
    busStart <= 1'b1;
    @(posedge clk);
    busStart <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(maxHigh, expLen)
    `CHK(eStalls, 8'h00)
  endtask : stretch
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    do_reset(1'b1);
    rdchk(CSS_IDX_STRETCH, 32'h00);
    do_reset(1'b0);
    rdchk(CSS_IDX_STRETCH, 32'h01);
    rdchk(CSS_IDX_CTL, 32'h04);
    for (int i = 8'h5c; i <= 8'h61; i++) rdchk(i[7:0], 32'h00);
    psel(16'h1800, 19'h01800, 4'b1110);
  endtask : t_reset
  task automatic t_layout();
    wr8(CSS_IDX_STRETCH, 8'he4);
    rdchk(CSS_IDX_STRETCH, 32'he4);
    wr8(CSS_IDX_G2CTL, 8'hff);
    rdchk(CSS_IDX_G2CTL, 32'h7f);
    wr8(CSS_IDX_G2CTL, 8'h00);
  endtask : t_layout
  task automatic t_io();
    wr8(CSS_IDX_CTL, 8'hf7);
    psel(16'h0800, 19'h00800, 4'b0111);
    psel(16'h1800, 19'h01800, 4'b1111);
    wr8(CSS_IDX_CTL, 8'he7);
    psel(16'h0800, 19'h00800, 4'b1111);
    wr8(CSS_IDX_CTL, 8'hc7);
    psel(16'h0800, 19'h00800, 4'b0111);
    // E-high validity, active high: the select must track the external E phase
    wr8(CSS_IDX_CTL, 8'hb7);
    cpuAddr <= 16'h1800;
    repeat (3) @(posedge clk);
    `CHK(ioRangeSelect, eClkOut)
    @(posedge clk);
    `CHK(ioRangeSelect, eClkOut)
  endtask : t_io
  task automatic t_prog();
    logic [15:0] base [4] = '{16'h0000, 16'h8000, 16'hc000, 16'he000};
    for (int k = 0; k < 4; k++) begin
      wr8(CSS_IDX_CTL, 8'h04 | k[7:0]);
      psel(base[k], {3'b000, base[k]}, 4'b1110);
      if (k > 0) psel(base[k] - 16'h1, {3'b000, base[k] - 16'h1}, 4'b1111);
    end
  endtask : t_prog
  task automatic t_gen();
    wr8(CSS_IDX_G1START, 8'h04);
    wr8(CSS_IDX_G1CTL, 8'h31);
    psel(16'h27ff, 19'h027ff, 4'b1111);
    psel(16'h2800, 19'h02800, 4'b1011);
    wr8(CSS_IDX_G1CTL, 8'h33);
    psel(16'h3fff, 19'h03fff, 4'b1111);
    psel(16'h4000, 19'h04000, 4'b1011);
    wr8(CSS_IDX_G1CTL, 8'h3a);
    win1Hit <= 1'b1;
    psel(16'h9000, 19'h09000, 4'b1111);
    win1Hit <= 1'b0;
    psel(16'h9000, 19'h09000, 4'b1011);
    wr8(CSS_IDX_G2START, 8'h08);
    wr8(CSS_IDX_G2CTL, 8'h11);
    psel(16'h4000, 19'h04000, 4'b1001);
    wr8(CSS_IDX_G2CTL, 8'h00);
  endtask : t_gen
  task automatic t_prio();
    wr8(CSS_IDX_G1CTL, 8'h31);
    wr8(CSS_IDX_CTL, 8'h04);
    psel(16'h2000, 19'h02000, 4'b1010);
    wr8(CSS_IDX_CTL, 8'h0c);
    psel(16'h2000, 19'h02000, 4'b1111);
    wr8(CSS_IDX_CTL, 8'h07);
  endtask : t_prio
  task automatic t_combine();
    wr8(CSS_IDX_G2CTL, 8'h31);
    wr8(CSS_IDX_G1CTL, 8'hb1);
    psel(16'h2000, 19'h02000, 4'b1011);
    wr8(CSS_IDX_G1CTL, 8'h71);
    psel(16'h2000, 19'h02000, 4'b1000);
    wr8(CSS_IDX_G1CTL, 8'h31);
    wr8(CSS_IDX_G2CTL, 8'h71);
    psel(16'h4000, 19'h04000, 4'b1000);
    wr8(CSS_IDX_G2CTL, 8'h00);
  endtask : t_combine
  task automatic t_exp();
    wr8(CSS_IDX_WINSIZE, 8'hc0);
    wr8(CSS_IDX_G1START, 8'h40);
    wr8(CSS_IDX_G2START, 8'h48);
    wr8(CSS_IDX_G2CTL, 8'h31);
    psel(16'h0000, 19'h20000, 4'b1101);
    psel(16'h0000, 19'h24000, 4'b1011);
    wr8(CSS_IDX_WINSIZE, 8'h00);
    wr8(CSS_IDX_G2CTL, 8'h00);
    wr8(CSS_IDX_G1START, 8'h04);
  endtask : t_exp
  task automatic t_stretch();
    for (int n = 0; n < 4; n++) begin
      wr8(CSS_IDX_STRETCH, n[7:0]);
      stretch(16'hf000, 8'd1 + 8'd2 * n[7:0]);
    end
    stretch(16'h6000, 8'd1);
    wr8(CSS_IDX_STRETCH, 8'h20);
    stretch(16'h2000, 8'd5);
  endtask : t_stretch
  initial begin
    t_reset();
    t_layout();
    t_io();
    t_prog();
    t_gen();
    t_prio();
    t_combine();
    t_exp();
    t_stretch();
    stop_test();
  end
endmodule : testbench
